// [core/bdmd_decode.sv]
// banked data memory decode with core registers and ram
`timescale 1ns/1ps
module bdmd_decode (
    input  wire logic       clock,
    input  wire logic       arst_n,
    input  wire logic       acc_valid,
    input  wire logic       acc_write,
    input  wire logic [6:0] acc_offset,
    input  wire logic [7:0] acc_wdata,
    output logic            rd_valid,
    output logic      [7:0] rd_data,
    output logic      [7:0] status,
    output logic      [7:0] file_select_pointer,
    output logic      [7:0] pc_low,
    output logic      [7:0] pc_latch,
    output logic      [7:0] int_control
);
    typedef struct packed {
        logic [7:0] status;
        logic [7:0] fsp;
        logic [7:0] pcl;
        logic [7:0] pclatch;
        logic [7:0] intctl;
        logic       rd_valid;
        logic       rd_from_ram;
        logic [7:0] rd_sfr;
    } bdmd_state_t;

    bdmd_state_t               s;
    bdmd_state_t               next_s;
    bdmd_pkg::bdmd_region_t    direct_region;
    bdmd_pkg::bdmd_region_t    eff_region;
    logic                [1:0] eff_bank;
    logic                [6:0] eff_off;
    logic                [7:0] sfr_value;

    bdmd_ram_if ram_bus ();

    bdmd_gpr_ram #(
        .WIDTH (bdmd_pkg::DATA_W),
        .DEPTH (bdmd_pkg::GPR_TOTAL)
    ) u_ram (
        .clock  (clock),
        .arst_n (arst_n),
        .ram    (ram_bus.mem)
    );

    // ------------------------------------------------------------
    // address resolution
    // ------------------------------------------------------------
    always_comb begin
        direct_region = bdmd_pkg::bdmd_region(acc_offset);
        // RQ6 direct path
        // RQ1 bank from status bits
        eff_bank      = {s.status[bdmd_pkg::ST_BANK_HIGH], s.status[bdmd_pkg::ST_BANK_LOW]};
        // RQ2 seven-bit in-bank offset
        eff_off       = acc_offset;
        eff_region    = direct_region;
        // RQ7 indirect slot redirected
        // RQ6 indirect path through pointer
        if (direct_region == bdmd_pkg::BDMD_R_INDIRECT) begin
            eff_bank   = {s.status[bdmd_pkg::ST_IND_BANK], s.fsp[7]};
            eff_off    = s.fsp[6:0];
            eff_region = bdmd_pkg::bdmd_region(s.fsp[6:0]);
            // pointer at the slot itself: nothing behind it
            if (eff_region == bdmd_pkg::BDMD_R_INDIRECT) begin
                eff_region = bdmd_pkg::BDMD_R_NONE;
            end
        end
    end

    // ------------------------------------------------------------
    // ram request and sfr read mux
    // ------------------------------------------------------------
    // RQ4 ram above the sfr region
    assign ram_bus.en    = acc_valid && (eff_region == bdmd_pkg::BDMD_R_GPR);
    assign ram_bus.we    = acc_write;
    assign ram_bus.index = bdmd_pkg::bdmd_gpr_index(eff_bank, eff_off);
    assign ram_bus.wdata = acc_wdata;

    always_comb begin
        // RQ5 one physical copy per alias
        // RQ9 same offsets in all banks
        unique case (eff_region)
            bdmd_pkg::BDMD_R_PCL:     sfr_value = s.pcl;
            bdmd_pkg::BDMD_R_STATUS:  sfr_value = s.status;
            bdmd_pkg::BDMD_R_FSP:     sfr_value = s.fsp;
            bdmd_pkg::BDMD_R_PCLATCH: sfr_value = s.pclatch;
            bdmd_pkg::BDMD_R_INTCTL:  sfr_value = s.intctl;
            // RQ8 unimplemented reads zero
            default:                  sfr_value = bdmd_pkg::READ_ZERO;
        endcase
    end

    // ------------------------------------------------------------
    // register update
    // ------------------------------------------------------------
    always_comb begin
        next_s             = s;
        next_s.rd_valid    = acc_valid && !acc_write;
        next_s.rd_from_ram = eff_region == bdmd_pkg::BDMD_R_GPR;
        next_s.rd_sfr      = sfr_value;
        // RQ8 writes to holes dropped
        if (acc_valid && acc_write) begin
            unique case (eff_region)
                bdmd_pkg::BDMD_R_PCL:     next_s.pcl     = acc_wdata;
                // read-only status flags keep their value
                bdmd_pkg::BDMD_R_STATUS:  next_s.status  = (acc_wdata & ~bdmd_pkg::ST_RO_MASK)
                                                         | (s.status & bdmd_pkg::ST_RO_MASK);
                bdmd_pkg::BDMD_R_FSP:     next_s.fsp     = acc_wdata;
                bdmd_pkg::BDMD_R_PCLATCH: next_s.pclatch = acc_wdata;
                bdmd_pkg::BDMD_R_INTCTL:  next_s.intctl  = acc_wdata;
                default:                  next_s.rd_sfr  = bdmd_pkg::READ_ZERO;
            endcase
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            s.status      <= bdmd_pkg::RST_STATUS;
            s.fsp         <= bdmd_pkg::RST_FSP;
            s.pcl         <= bdmd_pkg::RST_PCL;
            s.pclatch     <= bdmd_pkg::RST_PCLATCH;
            s.intctl      <= bdmd_pkg::RST_INTCTL;
            s.rd_valid    <= 1'b0;
            s.rd_from_ram <= 1'b0;
            s.rd_sfr      <= bdmd_pkg::READ_ZERO;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // mux of two flop banks; ram data is already registered
    assign rd_data             = s.rd_from_ram ? ram_bus.rdata : s.rd_sfr;
    assign rd_valid            = s.rd_valid;
    assign status              = s.status;
    assign file_select_pointer = s.fsp;
    assign pc_low              = s.pcl;
    assign pc_latch            = s.pclatch;
    assign int_control         = s.intctl;
endmodule

// [core/bdmd_gpr_ram.sv]
// general purpose static ram with registered read
`timescale 1ns/1ps
module bdmd_gpr_ram #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 336
) (
    input  wire logic clock,
    input  wire logic arst_n,
    bdmd_ram_if.mem   ram
);
    typedef struct packed {
        logic [WIDTH-1:0] rdata;
    } bdmd_ram_state_t;

    logic [WIDTH-1:0] mem [DEPTH];
    bdmd_ram_state_t  s;
    bdmd_ram_state_t  next_s;

    // index is nine bits wide, so depth stops at 512
    if (WIDTH != bdmd_pkg::DATA_W || DEPTH < bdmd_pkg::GPR_TOTAL || DEPTH > 512) begin : g_bad_size
        $error("bdmd_gpr_ram: unsupported width or depth");
    end

    assign ram.rdata = s.rdata;

    always_comb begin
        next_s = s;
        // RQ4 free read of ram
        if (ram.en && !ram.we) begin
            next_s.rdata = mem[ram.index];
        end
    end

    // ram cells are not reset; software must initialise them
    always_ff @(posedge clock) begin
        // RQ4 free write of ram
        if (ram.en && ram.we) begin
            mem[ram.index] <= ram.wdata;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule

// [core/bdmd_pkg.sv]
// constants, types and decode functions for the banked data memory decode
// Behaviour
// RQ1: the data bank comes from status bits 6:5, upper bit high select, 00 to 11 giving banks 0 to 3.
// RQ2: each bank spans in-bank offsets 00h to 7Fh, 128 byte locations on a 7-bit offset.
// RQ3: the lowest offsets of every bank decode to special function registers, not general storage.
// RQ4: offsets above the special function region decode to freely read and written static RAM.
// RQ5: a special function register reachable from several banks maps to one physical register.
// RQ6: accesses are either direct (offset plus bank bits) or indirect (file select pointer).
// RQ7: the indirect location at offset zero has no storage and is redirected through the pointer.
// RQ8: an unimplemented location reads as zero and ignores writes.
// RQ9: core registers sit at the same offsets in all banks; 70h-7Fh of banks 1 to 3 alias bank 0.
package bdmd_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int OFF_W  = 7;
    localparam int DATA_W = 8;
    localparam int IDX_W  = 9;

    // ------------------------------------------------------------
    // in-bank offsets
    // ------------------------------------------------------------
    localparam logic [6:0] OFF_INDIRECT  = 7'h00;
    localparam logic [6:0] OFF_PCL       = 7'h02;
    localparam logic [6:0] OFF_STATUS    = 7'h03;
    localparam logic [6:0] OFF_FSP       = 7'h04;
    localparam logic [6:0] OFF_PCLATCH   = 7'h0A;
    localparam logic [6:0] OFF_INTCTL    = 7'h0B;
    localparam logic [6:0] OFF_GPR_LO    = 7'h20;
    localparam logic [6:0] OFF_COMMON_LO = 7'h70;

    // ------------------------------------------------------------
    // status fields and reset values
    // ------------------------------------------------------------
    localparam int         ST_IND_BANK    = 7;
    localparam int         ST_BANK_HIGH   = 6;
    localparam int         ST_BANK_LOW    = 5;
    localparam logic [7:0] ST_RO_MASK     = 8'h18;
    localparam logic [7:0] RST_STATUS     = 8'h18;
    localparam logic [7:0] RST_FSP        = 8'h00;
    localparam logic [7:0] RST_PCL        = 8'h00;
    localparam logic [7:0] RST_PCLATCH    = 8'h00;
    localparam logic [7:0] RST_INTCTL     = 8'h00;
    localparam logic [7:0] READ_ZERO      = 8'h00;

    // ------------------------------------------------------------
    // general purpose ram layout
    // ------------------------------------------------------------
    localparam logic [8:0] GPR_BANK0_BYTES = 9'h060;
    localparam logic [8:0] GPR_BANKN_BYTES = 9'h050;
    localparam int         GPR_TOTAL       = 336;

    typedef enum logic [2:0] {
        BDMD_R_INDIRECT,
        BDMD_R_PCL,
        BDMD_R_STATUS,
        BDMD_R_FSP,
        BDMD_R_PCLATCH,
        BDMD_R_INTCTL,
        BDMD_R_GPR,
        BDMD_R_NONE
    } bdmd_region_t;

    // ------------------------------------------------------------
    // decode functions
    // ------------------------------------------------------------
    // RQ3 sfr region decode
    function automatic bdmd_region_t bdmd_region(input logic [6:0] off);
        bdmd_region_t r;
        r = BDMD_R_NONE;
        if (off >= OFF_GPR_LO) begin
            r = BDMD_R_GPR;
        end else begin
            unique case (off)
                OFF_INDIRECT: r = BDMD_R_INDIRECT;
                OFF_PCL:      r = BDMD_R_PCL;
                OFF_STATUS:   r = BDMD_R_STATUS;
                OFF_FSP:      r = BDMD_R_FSP;
                OFF_PCLATCH:  r = BDMD_R_PCLATCH;
                OFF_INTCTL:   r = BDMD_R_INTCTL;
                default:      r = BDMD_R_NONE;
            endcase
        end
        return r;
    endfunction

    // RQ9 common window folds to bank 0
    function automatic logic [8:0] bdmd_gpr_index(input logic [1:0] bank,
                                                  input logic [6:0] off);
        logic [8:0] rel;
        logic [8:0] base;
        rel  = {2'b00, off - OFF_GPR_LO};
        base = 9'(GPR_BANKN_BYTES * {7'h00, bank - 2'h1});
        if (bank == 2'h0 || off >= OFF_COMMON_LO) begin
            return rel;
        end
        return GPR_BANK0_BYTES + base + rel;
    endfunction

endpackage

// [core/bdmd_ram_if.sv]
// carrier between the decode and the general purpose ram
`timescale 1ns/1ps
interface bdmd_ram_if;
    logic       en;
    logic       we;
    logic [8:0] index;
    logic [7:0] wdata;
    logic [7:0] rdata;

    modport ctrl (output en, output we, output index, output wdata, input rdata);
    modport mem  (input en, input we, input index, input wdata, output rdata);
endinterface

// [test/bdmd_core_model.sv]
// behavioural core issuing direct and indirect data accesses
`timescale 1ns/1ps
module bdmd_core_model (
    input  wire logic       clock,
    output logic            acc_valid,
    output logic            acc_write,
    output logic      [6:0] acc_offset,
    output logic      [7:0] acc_wdata,
    input  wire logic       rd_valid,
    input  wire logic [7:0] rd_data
);
    initial begin
        acc_valid  = 1'b0;
        acc_write  = 1'b0;
        acc_offset = 7'h00;
        acc_wdata  = 8'h00;
    end

    // entered at a falling edge; request left up so back-to-back calls never glitch
    task automatic xfer(input logic we, input logic [6:0] off, input logic [7:0] wd,
                        output logic v, output logic [7:0] rd);
        acc_valid  = 1'b1;
        acc_write  = we;
        acc_offset = off;
        acc_wdata  = wd;
        @(negedge clock);
        v  = rd_valid;
        rd = rd_data;
    endtask

    // released lines scrambled so a stale value cannot pass
    task automatic idle();
        acc_valid  = 1'b0;
        acc_write  = ~acc_write;
        acc_offset = ~acc_offset;
        acc_wdata  = ~acc_wdata;
        @(negedge clock);
    endtask
endmodule

// [test/bdmd_decode_assertions.sv]
// port checker for the banked data memory decode
`timescale 1ns/1ps
module bdmd_decode_assertions (
    input wire logic       clock,
    input wire logic       arst_n,
    input wire logic       acc_valid,
    input wire logic       acc_write,
    input wire logic [6:0] acc_offset,
    input wire logic [7:0] acc_wdata,
    input wire logic       rd_valid,
    input wire logic [7:0] rd_data,
    input wire logic [7:0] status,
    input wire logic [7:0] file_select_pointer,
    input wire logic [7:0] pc_low,
    input wire logic [7:0] pc_latch,
    input wire logic [7:0] int_control
);
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);

    AST_READ_ANSWER: assert property (acc_valid && !acc_write |=> rd_valid)
        else $error("read not answered next cycle");
    AST_NO_SPURIOUS: assert property (!(acc_valid && !acc_write) |=> !rd_valid)
        else $error("read valid without a read");
    AST_STATUS_WRITE: assert property (acc_valid && acc_write && acc_offset == 7'h03 |=>
        status == (($past(acc_wdata) & 8'hE7) | ($past(status) & 8'h18)))
        else $error("status write wrong");
    AST_POINTER_WRITE: assert property (acc_valid && acc_write && acc_offset == 7'h04 |=>
        file_select_pointer == $past(acc_wdata))
        else $error("pointer write wrong");
    AST_PCL_WRITE: assert property (acc_valid && acc_write && acc_offset == 7'h02 |=>
        pc_low == $past(acc_wdata))
        else $error("pc low write wrong");
    AST_UNIMPL_READ: assert property (acc_valid && !acc_write && acc_offset == 7'h01 |=>
        rd_data == 8'h00)
        else $error("unimplemented read not zero");
    AST_STATUS_READ: assert property (acc_valid && !acc_write && acc_offset == 7'h03 |=>
        rd_data == $past(status))
        else $error("status read wrong");
    AST_INDIRECT_NULL: assert property (acc_valid && !acc_write && acc_offset == 7'h00
        && file_select_pointer[6:0] == 7'h00 |=> rd_data == 8'h00)
        else $error("null indirect read not zero");
endmodule

bind bdmd_decode bdmd_decode_assertions bdmd_decode_assertions_i (.clock, .arst_n,
    .acc_valid, .acc_write, .acc_offset, .acc_wdata, .rd_valid, .rd_data, .status,
    .file_select_pointer, .pc_low, .pc_latch, .int_control);

// [test/bdmd_decode_tb.sv]
// self-checking bench for the banked data memory decode
`timescale 1ns/1ps
module bdmd_decode_tb;
    logic       clock;
    logic       arst_n;
    logic       acc_valid, acc_write, rd_valid;
    logic [6:0] acc_offset;
    logic [7:0] acc_wdata, rd_data, status, file_select_pointer;
    logic [7:0] pc_low, pc_latch, int_control;
    int         fails = 0;
    int         compares = 0;
    int         cycles = 0;

    bdmd_decode bdmd_decode_i (.clock, .arst_n, .acc_valid, .acc_write, .acc_offset,
        .acc_wdata, .rd_valid, .rd_data, .status, .file_select_pointer, .pc_low,
        .pc_latch, .int_control);
    bdmd_core_model bdmd_core_model_i (.clock, .acc_valid, .acc_write, .acc_offset,
        .acc_wdata, .rd_valid, .rd_data);

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [6:0] off, input logic [7:0] d);
        logic       v;
        logic [7:0] r;
        bdmd_core_model_i.xfer(1'b1, off, d, v, r);
        check({7'h00, v}, 8'h00);
    endtask

    task automatic rd(input logic [6:0] off, input logic [7:0] exp);
        logic       v;
        logic [7:0] r;
        bdmd_core_model_i.xfer(1'b0, off, 8'h00, v, r);
        check({7'h00, v}, 8'h01);
        check(r, exp);
    endtask

    task automatic summarize();
        if (fails == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // run needs about 75 cycles
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            fails++;
            summarize();
        end
    end

    initial begin
        arst_n = 1'b0;
        repeat (10) @(negedge clock);
        arst_n = 1'b1;
        check(status, 8'h18);
        check(file_select_pointer | pc_low | pc_latch | int_control, 8'h00);
        for (int b = 0; b < 4; b++) begin
            wr(7'h03, 8'(b << 5));
            check(status, 8'(b << 5) | 8'h18);
            wr(7'h20, 8'hA0 + 8'(b));
            wr(7'h7F, 8'hC0 + 8'(b));
            wr(7'h02, 8'h10 + 8'(b));
        end
        // bank 3 wrote last, so shared places hold its values
        for (int b = 0; b < 4; b++) begin
            wr(7'h03, 8'(b << 5));
            rd(7'h20, 8'hA0 + 8'(b));
            rd(7'h7F, 8'hC3);
            rd(7'h02, 8'h13);
            rd(7'h03, 8'(b << 5) | 8'h18);
            wr(7'h01, 8'h55);
            rd(7'h01, 8'h00);
        end
        wr(7'h0A, 8'h1F);
        wr(7'h0B, 8'hC3);
        wr(7'h03, 8'h00);
        check(status, 8'h18);
        check(pc_latch ^ int_control, 8'hDC);
        rd(7'h0A, 8'h1F);
        rd(7'h0B, 8'hC3);
        wr(7'h04, 8'hA0);
        rd(7'h00, 8'hA1);
        wr(7'h00, 8'h5A);
        wr(7'h03, 8'h20);
        rd(7'h20, 8'h5A);
        wr(7'h03, 8'h80);
        wr(7'h04, 8'h20);
        rd(7'h00, 8'hA2);
        wr(7'h04, 8'hFF);
        rd(7'h00, 8'hC3);
        wr(7'h04, 8'h80);
        wr(7'h00, 8'h77);
        rd(7'h00, 8'h00);
        check(file_select_pointer, 8'h80);
        bdmd_core_model_i.idle();
        arst_n = 1'b0;
        @(negedge clock);
        arst_n = 1'b1;
        check(status, 8'h18);
        summarize();
    end
endmodule
